// ---- bert_pkg.sv ----
// constants and helpers shared by the bit error rate tester
// assumes a single 25 MHz core clock and an AHB-Lite register port
package bert_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int SEC_PERIOD_NS = 1000000000;
  localparam int SEC_CYCLES    = SEC_PERIOD_NS / CLK_PERIOD_NS;

  localparam logic [7:0] A_CTRL     = 8'h00;
  localparam logic [7:0] A_RESTART  = 8'h04;
  localparam logic [7:0] A_BER      = 8'h08;
  localparam logic [7:0] A_LOSS     = 8'h0C;
  localparam logic [7:0] A_ERRORS   = 8'h10;
  localparam logic [7:0] A_BITS_LO  = 8'h14;
  localparam logic [7:0] A_BITS_HI  = 8'h18;
  localparam logic [7:0] A_EFS      = 8'h1C;
  localparam logic [7:0] A_ERRSEC   = 8'h20;
  localparam logic [7:0] A_TOTSEC   = 8'h24;
  localparam logic [7:0] A_TX_PPM   = 8'h28;
  localparam logic [7:0] A_RX_PPM   = 8'h2C;
  localparam logic [7:0] A_NOM_RATE = 8'h30;
  localparam logic [7:0] A_STATUS   = 8'h34;
  localparam logic [7:0] A_IRQ_STAT = 8'h38;
  localparam logic [7:0] A_IRQ_MASK = 8'h3C;

  localparam int CTRL_TX_LSB  = 0;
  localparam int CTRL_RX_LSB  = 2;
  localparam int CTRL_DIR_BIT = 4;
  localparam int IRQ_LOSS     = 0;
  localparam int IRQ_LOCK     = 1;
  localparam int IRQ_ERRSEC   = 2;
  localparam int IRQ_RESULT   = 3;

  localparam logic [1:0] PAT_OFF  = 2'h0;
  localparam logic [1:0] PAT_2047 = 2'h1;
  localparam logic [1:0] PAT_23   = 2'h2;
  localparam logic [1:0] PAT_INJ  = 2'h3;
  localparam logic       DIR_SAT  = 1'b0;

  localparam int SHORT_TAP_A = 10;
  localparam int SHORT_TAP_B = 8;
  localparam int LONG_TAP_A  = 22;
  localparam int LONG_TAP_B  = 17;
  localparam logic [22:0] SEED = 23'h7FFFFF;

  localparam logic [5:0]  SYNC_MATCH    = 6'h20;
  localparam logic [5:0]  LOSS_WIN_LAST = 6'h3F;
  localparam logic [6:0]  LOSS_ERR      = 7'h10;
  localparam logic [63:0] PPM_SCALE     = 64'hF4240;
  localparam logic [63:0] EFS_SCALE     = 64'h2710;
  localparam logic [6:0]  DIV_STEPS     = 7'h40;

  function automatic logic prbs_fb(input logic [1:0] mode,
                                   input logic [22:0] sr);
    if (mode == PAT_2047)
      return sr[SHORT_TAP_A] ^ sr[SHORT_TAP_B];
    return sr[LONG_TAP_A] ^ sr[LONG_TAP_B];
  endfunction
endpackage

// ---- bert_div_if.sv ----
// operand and result wires between the tester and its divider
// assumes start is a one-cycle pulse and operands hold during that cycle
`timescale 1ns/1ps
interface bert_div_if;
  logic        start;
  logic [63:0] num;
  logic [47:0] den;
  logic        done;
  logic [31:0] quo;
  modport ctl (output start, num, den, input done, quo);
  modport eng (input start, num, den, output done, quo);
endinterface

// ---- bert_div.sv ----
// sequential unsigned divider, one quotient bit per clock
// assumes start only while idle; a quotient above 32 bits saturates
`timescale 1ns/1ps
module bert_div (
  input wire logic  clk_in,
  input wire logic  rst_in,
  bert_div_if.eng   dv
);
  typedef struct packed {
    logic        busy;
    logic [6:0]  cnt;
    logic [63:0] q;
    logic [48:0] rem;
    logic [47:0] den;
    logic        done;
    logic [31:0] quo;
  } bert_div_s;

  bert_div_s   r;
  bert_div_s   n;
  logic [48:0] sh;

  always_comb begin
    n = r;
    n.done = 1'b0;
    sh = {r.rem[47:0], r.q[63]};
    if (r.busy) begin
      if (sh >= {1'b0, r.den}) begin
        n.rem = sh - {1'b0, r.den};
        n.q = {r.q[62:0], 1'b1};
      end else begin
        n.rem = sh;
        n.q = {r.q[62:0], 1'b0};
      end
      n.cnt = r.cnt - 7'h1;
      if (r.cnt == 7'h1) begin
        n.busy = 1'b0;
        n.done = 1'b1;
        n.quo = (|n.q[63:32]) ? 32'hFFFFFFFF : n.q[31:0];
      end
    end else if (dv.start) begin
      n.busy = 1'b1;
      n.cnt = bert_pkg::DIV_STEPS;
      n.q = dv.num;
      n.rem = '0;
      n.den = dv.den;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in)
      r <= '0;
    else
      r <= n;
  end

  assign dv.done = r.done;
  assign dv.quo = r.quo;
endmodule

// ---- bert_top.sv ----
// bit error rate tester: pattern generator, checker, clock monitors
// assumes bit clocks and data arrive from pins, foreign to core_clk_in
`timescale 1ns/1ps
module bert_top #(
  parameter int SEC_CYCLES = bert_pkg::SEC_CYCLES
) (
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic        hsel_in,
  input  wire logic [7:0]  haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  output logic             irq_out,
  input  wire logic        tx_bit_clk_in,
  input  wire logic        rx_bit_clk_in,
  input  wire logic        ter_send_data_in,
  input  wire logic        sat_rx_data_in,
  output logic             mod_data_out,
  output logic             ter_rcv_data_out
);
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_BER  = 5'h02,
    S_EFS  = 5'h04,
    S_PTX  = 5'h08,
    S_PRX  = 5'h10
  } bert_job_e;
  typedef struct packed {
    logic [1:0]  txc_s, rxc_s, tsd_s, rsd_s;
    logic        txc_p, rxc_p, dir, inj, gbit, synced, err_in_sec;
    logic [1:0]  tx_mode, rx_mode;
    logic [31:0] nom, errors, errsec, totsec, sec_cnt;
    logic [22:0] gen_sr, chk_sr;
    logic [5:0]  match, win_cnt;
    logic [6:0]  win_err;
    logic [15:0] losses;
    logic [47:0] bits;
    logic [31:0] tx_edges, rx_edges, tx_last, rx_last;
    logic [31:0] ber, error_free_seconds_pct, tx_ppm, rx_ppm;
    bert_job_e   st;
    logic        dstart, irq, ap, a_wr, hready, mod_data, ter_data;
    logic [3:0]  irq_st, irq_mask;
    logic [7:0]  a_addr;
    logic [31:0] hrdata;
  } bert_state_s;
  bert_state_s r, n;
  logic        tx_edge, rx_edge, gen_edge, chk_edge, chk_bit, exp_bit;
  logic        fb, mis, tick, restart_w, inj_w;
  logic [3:0]  ev;
  logic [31:0] rd, ppm_meas;
  bert_div_if dv ();
  bert_div u_div (
    .clk_in (core_clk_in),
    .rst_in (rst_in),
    .dv     (dv.eng)
  );
  function automatic logic [31:0] absdiff(input logic [31:0] a,
                                          input logic [31:0] b);
    return (a >= b) ? a - b : b - a;
  endfunction
  // quotient is a magnitude; sign follows the side of nominal
  function automatic logic [31:0] ppm_val(input logic [31:0] q,
                                          input logic [31:0] meas,
                                          input logic [31:0] nom);
    logic [31:0] m;
    m = q[31] ? 32'h7FFFFFFF : q;
    if (nom == 32'h0)
      return 32'h0;
    return (meas >= nom) ? m : 32'h0 - m;
  endfunction
  // operands are read straight from state; the divider latches them
  assign ppm_meas = (r.st == S_PTX) ? r.tx_last : r.rx_last;
  assign dv.start = r.dstart;
  assign dv.num = (r.st == S_BER) ? {r.errors, 32'h0} :
                  (r.st == S_EFS) ?
                    64'(r.totsec - r.errsec) * bert_pkg::EFS_SCALE :
                    64'(absdiff(ppm_meas, r.nom)) * bert_pkg::PPM_SCALE;
  assign dv.den = (r.st == S_BER) ? r.bits :
                  (r.st == S_EFS) ? {16'h0, r.totsec} : {16'h0, r.nom};
  always_comb begin
    n = r;
    n.dstart = 1'b0;
    restart_w = 1'b0;
    inj_w = r.inj;
    ev = 4'h0;
    mis = 1'b0;
    exp_bit = 1'b0;
    fb = 1'b0;
    // two flops on every pin before anything looks at it
    n.txc_s = {r.txc_s[0], tx_bit_clk_in};
    n.rxc_s = {r.rxc_s[0], rx_bit_clk_in};
    n.tsd_s = {r.tsd_s[0], ter_send_data_in};
    n.rsd_s = {r.rsd_s[0], sat_rx_data_in};
    n.txc_p = r.txc_s[1];
    n.rxc_p = r.rxc_s[1];
    tx_edge = r.txc_s[1] & ~r.txc_p;
    rx_edge = r.rxc_s[1] & ~r.rxc_p;
    gen_edge = (r.dir == bert_pkg::DIR_SAT) ? tx_edge : rx_edge;
    chk_edge = (r.dir == bert_pkg::DIR_SAT) ? rx_edge : tx_edge;
    chk_bit = (r.dir == bert_pkg::DIR_SAT) ? r.rsd_s[1] : r.tsd_s[1];
    tick = (r.sec_cnt == 32'(SEC_CYCLES - 1));
    n.sec_cnt = tick ? 32'h0 : r.sec_cnt + 32'h1;

    case (r.a_addr)
      bert_pkg::A_CTRL:     rd = {27'h0, r.dir, r.rx_mode, r.tx_mode};
      bert_pkg::A_BER:      rd = r.ber;
      bert_pkg::A_LOSS:     rd = {16'h0, r.losses};
      bert_pkg::A_ERRORS:   rd = r.errors;
      bert_pkg::A_BITS_LO:  rd = r.bits[31:0];
      bert_pkg::A_BITS_HI:  rd = {16'h0, r.bits[47:32]};
      bert_pkg::A_EFS:      rd = r.error_free_seconds_pct;
      bert_pkg::A_ERRSEC:   rd = r.errsec;
      bert_pkg::A_TOTSEC:   rd = r.totsec;
      bert_pkg::A_TX_PPM:   rd = r.tx_ppm;
      bert_pkg::A_RX_PPM:   rd = r.rx_ppm;
      bert_pkg::A_NOM_RATE: rd = r.nom;
      bert_pkg::A_STATUS:   rd = {30'h0, r.inj, r.synced};
      bert_pkg::A_IRQ_STAT: rd = {28'h0, r.irq_st};
      bert_pkg::A_IRQ_MASK: rd = {28'h0, r.irq_mask};
      default:              rd = 32'h0;
    endcase

    // one wait state so that read data leaves a flop
    if (r.ap) begin
      n.ap = 1'b0;
      n.hready = 1'b1;
      if (!r.a_wr)
        n.hrdata = rd;
      else begin
        case (r.a_addr)
          bert_pkg::A_CTRL: begin
            if (hwdata_in[bert_pkg::CTRL_TX_LSB +: 2] == bert_pkg::PAT_INJ)
              inj_w = r.inj | (r.tx_mode != bert_pkg::PAT_OFF);
            else
              n.tx_mode = hwdata_in[bert_pkg::CTRL_TX_LSB +: 2];
            n.rx_mode = hwdata_in[bert_pkg::CTRL_RX_LSB +: 2];
            if (n.rx_mode == bert_pkg::PAT_INJ)
              n.rx_mode = bert_pkg::PAT_OFF;
            n.dir = hwdata_in[bert_pkg::CTRL_DIR_BIT];
            restart_w = (n.rx_mode != r.rx_mode);
          end
          bert_pkg::A_RESTART:  restart_w = hwdata_in[0];
          bert_pkg::A_NOM_RATE: n.nom = hwdata_in;
          bert_pkg::A_IRQ_STAT: n.irq_st = r.irq_st & ~hwdata_in[3:0];
          bert_pkg::A_IRQ_MASK: n.irq_mask = hwdata_in[3:0];
          default: ;
        endcase
      end
    end
    if (hsel_in && htrans_in[1] && hready_in) begin
      n.ap = 1'b1;
      n.hready = 1'b0;
      n.a_wr = hwrite_in;
      n.a_addr = haddr_in;
    end

    // totals cleared first so that a same-cycle event still counts
    if (restart_w) begin
      n.errors = 32'h0;
      n.losses = 16'h0;
      n.bits = 48'h0;
      n.errsec = 32'h0;
      n.totsec = 32'h0;
      n.err_in_sec = 1'b0;
      n.ber = 32'h0;
      n.error_free_seconds_pct = 32'h0;
    end

    // generator; an injected error flips one bit, pattern runs on clean
    if (r.tx_mode != bert_pkg::PAT_OFF && gen_edge) begin
      fb = bert_pkg::prbs_fb(r.tx_mode, r.gen_sr);
      n.gbit = fb ^ r.inj;
      // a request landing on this very edge merges into the one used up
      if (r.inj)
        inj_w = 1'b0;
      n.gen_sr = {r.gen_sr[21:0], fb};
      // only a dead register reseeds; 11 zeros are legal in the long one
      if ((r.tx_mode == bert_pkg::PAT_2047) ? (r.gen_sr[10:0] == 11'h0) :
          (r.gen_sr == 23'h0))
        n.gen_sr = bert_pkg::SEED;
    end
    n.inj = (n.tx_mode == bert_pkg::PAT_OFF) ? 1'b0 : inj_w;

    // checker: free load until sync, then flywheel on its own pattern
    // a new select drops sync: the old history predicts the wrong pattern
    if (r.rx_mode == bert_pkg::PAT_OFF || n.rx_mode != r.rx_mode) begin
      n.synced = 1'b0;
      n.match = 6'h0;
    end else if (chk_edge) begin
      exp_bit = bert_pkg::prbs_fb(r.rx_mode, r.chk_sr);
      if (!r.synced) begin
        n.chk_sr = {r.chk_sr[21:0], chk_bit};
        if ((exp_bit ^ chk_bit) || r.chk_sr[10:0] == 11'h0)
          n.match = 6'h0;
        else if (r.match == bert_pkg::SYNC_MATCH - 6'h1) begin
          n.synced = 1'b1;
          n.match = 6'h0;
          n.win_cnt = 6'h0;
          n.win_err = 7'h0;
          ev[bert_pkg::IRQ_LOCK] = 1'b1;
        end else
          n.match = r.match + 6'h1;
      end else begin
        mis = exp_bit ^ chk_bit;
        n.chk_sr = {r.chk_sr[21:0], exp_bit};
        if (!(&n.bits))
          n.bits = n.bits + 48'h1;
        if (mis) begin
          if (!(&n.errors))
            n.errors = n.errors + 32'h1;
          n.err_in_sec = 1'b1;
        end
        n.win_err = r.win_err + {6'h0, mis};
        n.win_cnt = r.win_cnt + 6'h1;
        if (r.win_cnt == bert_pkg::LOSS_WIN_LAST) begin
          n.win_cnt = 6'h0;
          n.win_err = 7'h0;
          if (r.win_err + {6'h0, mis} >= bert_pkg::LOSS_ERR) begin
            n.synced = 1'b0;
            ev[bert_pkg::IRQ_LOSS] = 1'b1;
            if (!(&n.losses))
              n.losses = n.losses + 16'h1;
          end
        end
      end
    end

    // clock edges per second against the core clock
    if (tick) begin
      n.tx_last = r.tx_edges;
      n.rx_last = r.rx_edges;
      n.tx_edges = {31'h0, tx_edge};
      n.rx_edges = {31'h0, rx_edge};
      if (r.rx_mode != bert_pkg::PAT_OFF) begin
        if (!(&n.totsec))
          n.totsec = n.totsec + 32'h1;
        if (n.err_in_sec) begin
          if (!(&n.errsec))
            n.errsec = n.errsec + 32'h1;
          ev[bert_pkg::IRQ_ERRSEC] = 1'b1;
        end
        n.err_in_sec = 1'b0;
      end
      if (r.st == S_IDLE) begin
        n.st = S_BER;
        n.dstart = 1'b1;
      end
    end else begin
      if (tx_edge && !(&r.tx_edges))
        n.tx_edges = r.tx_edges + 32'h1;
      if (rx_edge && !(&r.rx_edges))
        n.rx_edges = r.rx_edges + 32'h1;
    end

    // results once a second, one division after another
    case (r.st)
      S_IDLE: ;
      S_BER: if (dv.done) begin
        n.ber = (r.bits == 48'h0) ? 32'h0 : dv.quo;
        n.st = S_EFS;
        n.dstart = 1'b1;
      end
      S_EFS: if (dv.done) begin
        n.error_free_seconds_pct = (r.totsec == 32'h0) ? 32'h0 : dv.quo;
        n.st = S_PTX;
        n.dstart = 1'b1;
      end
      S_PTX: if (dv.done) begin
        n.tx_ppm = ppm_val(dv.quo, r.tx_last, r.nom);
        n.st = S_PRX;
        n.dstart = 1'b1;
      end
      S_PRX: if (dv.done) begin
        n.rx_ppm = ppm_val(dv.quo, r.rx_last, r.nom);
        n.st = S_IDLE;
        ev[bert_pkg::IRQ_RESULT] = 1'b1;
      end
      default: n.st = S_IDLE;
    endcase

    // set wins over a same-cycle write-one clear
    n.irq_st = n.irq_st | ev;
    n.irq = |(n.irq_st & n.irq_mask);
    n.mod_data = (r.tx_mode != bert_pkg::PAT_OFF &&
                  r.dir == bert_pkg::DIR_SAT) ? r.gbit : r.tsd_s[1];
    n.ter_data = (r.tx_mode != bert_pkg::PAT_OFF &&
                  r.dir != bert_pkg::DIR_SAT) ? r.gbit : r.rsd_s[1];
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      r <= '0;
      r.gen_sr <= bert_pkg::SEED;
      r.st <= S_IDLE;
      r.hready <= 1'b1;
    end else
      r <= n;
  end

  assign hrdata_out = r.hrdata;
  assign hreadyout_out = r.hready;
  assign hresp_out = 1'b0;
  assign irq_out = r.irq;
  assign mod_data_out = r.mod_data;
  assign ter_rcv_data_out = r.ter_data;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  inj_needs_gen_a: assert property (
    r.tx_mode == bert_pkg::PAT_OFF |-> !r.inj)
    else $error("error pending while generator off");
  inj_flips_bit_a: assert property (
    (gen_edge && r.tx_mode != bert_pkg::PAT_OFF && r.inj) |=>
      r.gbit != $past(fb))
    else $error("injected bit not inverted");
  rx_off_nosync_a: assert property (
    r.rx_mode == bert_pkg::PAT_OFF |=> !r.synced)
    else $error("checker synced while off");
  ber_store_a: assert property (
    (r.st == S_BER && dv.done && r.bits != 48'h0) |=>
      r.ber == $past(dv.quo))
    else $error("ratio not stored");
  loss_count_a: assert property (
    (ev[bert_pkg::IRQ_LOSS] && !restart_w && !(&r.losses)) |=>
      (r.losses == $past(r.losses) + 16'h1) && !r.synced)
    else $error("sync loss not counted");
  err_count_a: assert property (
    (mis && !restart_w && !(&r.errors)) |=>
      r.errors == $past(r.errors) + 32'h1)
    else $error("bit error not counted");
  bit_count_a: assert property (
    (chk_edge && r.synced && r.rx_mode != bert_pkg::PAT_OFF &&
     !restart_w && !(&r.bits)) |=> r.bits == $past(r.bits) + 48'h1)
    else $error("checked bit not counted");
  errsec_count_a: assert property (
    (tick && r.rx_mode != bert_pkg::PAT_OFF && r.err_in_sec &&
     !restart_w) |=> (r.errsec != $past(r.errsec)) || (&r.errsec))
    else $error("errored second missed");
  sec_count_a: assert property (
    (tick && r.rx_mode != bert_pkg::PAT_OFF && !restart_w &&
     !(&r.totsec)) |=> r.totsec == $past(r.totsec) + 32'h1)
    else $error("second not counted");
  restart_clear_a: assert property (
    restart_w |=> r.errors <= 32'h1 && r.losses <= 16'h1 &&
      r.totsec <= 32'h1 && r.bits <= 48'h1)
    else $error("restart left totals");
  ppm_job_a: assert property (
    (r.st == S_PTX && $past(r.st) != S_PTX) |->
      ##[60:80] (r.st == S_PRX))
    else $error("offset result late");
  sat_route_a: assert property (
    (r.tx_mode != bert_pkg::PAT_OFF && r.dir == bert_pkg::DIR_SAT) |=>
      mod_data_out == $past(r.gbit))
    else $error("pattern not on modulator path");
endmodule

// ---- bert_modem_model.sv ----
// modem data path model: one free running bit clock for both directions
// assumes the tester drives data a few core cycles after each rising edge
`timescale 1ns/1ps
module bert_modem_model #(
  parameter int HALF_NS = 320
) (
  input  wire logic invert_in,
  input  wire logic mod_data_in,
  input  wire logic ter_data_in,
  output logic      bit_clk_out,
  output logic      sat_data_out,
  output logic      ter_send_out
);
  initial begin
    bit_clk_out = 1'b0;
    sat_data_out = 1'b0;
    ter_send_out = 1'b1;
    #7;
    forever #HALF_NS bit_clk_out = ~bit_clk_out;
  end

  // sample mid bit so the retimed copy never catches a transition
  always @(negedge bit_clk_out) begin
    sat_data_out <= mod_data_in ^ invert_in;
    ter_send_out <= ter_data_in ^ invert_in;
  end
endmodule

// ---- testbench.sv ----
// register level tests of the tester over a looped back modem model
// assumes the second is shortened to SEC core cycles
`timescale 1ns/1ps
module testbench;
  localparam int SEC = 2000;
  logic        core_clk, rst, hsel, hwrite, hready, irq, hresp;
  logic        bit_clk, inv, mod_data, ter_rcv, sat_data, ter_send;
  logic [1:0]  htrans;
  logic [7:0]  haddr;
  logic [31:0] hwdata, hrdata, v;
  int          miscompares, cmp_count;

  bert_top #(.SEC_CYCLES(SEC)) uut (
    .core_clk_in(core_clk), .rst_in(rst), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .irq_out(irq), .tx_bit_clk_in(bit_clk), .rx_bit_clk_in(bit_clk),
    .ter_send_data_in(ter_send), .sat_rx_data_in(sat_data),
    .mod_data_out(mod_data), .ter_rcv_data_out(ter_rcv));

  bert_modem_model modem (
    .invert_in(inv), .mod_data_in(mod_data), .ter_data_in(ter_rcv),
    .bit_clk_out(bit_clk), .sat_data_out(sat_data),
    .ter_send_out(ter_send));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic end_sim;
    if (miscompares == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // address phase held until hready, then data phase until hready again
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    v = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic wait_sec(input int n);
    repeat (n * SEC) @(posedge core_clk);
  endtask

  initial begin
    repeat (60000) @(posedge core_clk);
    miscompares++;
    end_sim();
  end

  initial begin
    miscompares = 0;
    cmp_count = 0;
    rst = 1'b1;
    inv = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 8'h00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    rd(bert_pkg::A_CTRL); check(v, 32'h0);
    rd(8'h40); check(v, 32'h0);
    rd(bert_pkg::A_NOM_RATE); check(v, 32'h0);
    check({31'h0, hresp}, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr(bert_pkg::A_NOM_RATE, 32'h64);
    wr(bert_pkg::A_IRQ_MASK, 32'h1);
    rd(bert_pkg::A_IRQ_MASK); check(v, 32'h1);
    // both patterns, checker looped onto the generator
    for (int m = 1; m < 3; m++) begin
      wr(bert_pkg::A_CTRL, 32'(m) | 32'(m << 2));
      wait_sec(2);
      rd(bert_pkg::A_STATUS); check(v, 32'h1);
      rd(bert_pkg::A_ERRORS); check(v, 32'h0);
      rd(bert_pkg::A_LOSS); check(v, 32'h0);
      rd(bert_pkg::A_BER); check(v, 32'h0);
      rd(bert_pkg::A_BITS_LO); check({31'h0, v != 0}, 32'h1);
    end
    wr(bert_pkg::A_RESTART, 32'h1);
    rd(bert_pkg::A_TOTSEC); check(v, 32'h0);
    wait_sec(3);
    rd(bert_pkg::A_TOTSEC); check({31'h0, v == 2 || v == 3}, 32'h1);
    rd(bert_pkg::A_EFS); check(v, 32'h2710);
    // 125 edges a second against a nominal 100, one edge of slack
    rd(bert_pkg::A_TX_PPM);
    check({31'h0, v >= 32'h3A980 && v <= 32'h3F7A0}, 32'h1);
    rd(bert_pkg::A_RX_PPM);
    check({31'h0, v >= 32'h3A980 && v <= 32'h3F7A0}, 32'h1);
    wr(bert_pkg::A_CTRL, 32'hB);
    wait_sec(2);
    rd(bert_pkg::A_CTRL); check(v, 32'hA);
    rd(bert_pkg::A_ERRORS); check({31'h0, v >= 1 && v <= 3}, 32'h1);
    rd(bert_pkg::A_ERRSEC); check(v, 32'h1);
    rd(bert_pkg::A_BER); check({31'h0, v != 0}, 32'h1);
    rd(bert_pkg::A_EFS); check({31'h0, v < 32'h2710}, 32'h1);
    // inverted stream breaks sync; released stream regains it
    inv <= 1'b1;
    wait_sec(1);
    inv <= 1'b0;
    wait_sec(1);
    rd(bert_pkg::A_LOSS); check(v, 32'h1);
    check({31'h0, irq}, 32'h1);
    wr(bert_pkg::A_IRQ_MASK, 32'h0);
    repeat (3) @(posedge core_clk);
    check({31'h0, irq}, 32'h0);
    wr(bert_pkg::A_IRQ_MASK, 32'h1);
    wr(bert_pkg::A_IRQ_STAT, 32'h1);
    rd(bert_pkg::A_IRQ_STAT); check(v & 32'h1, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr(bert_pkg::A_RESTART, 32'h1);
    rd(bert_pkg::A_LOSS); check(v, 32'h0);
    rd(bert_pkg::A_ERRORS); check(v, 32'h0);
    rd(bert_pkg::A_ERRSEC); check(v, 32'h0);
    rd(bert_pkg::A_BITS_HI); check(v, 32'h0);
    // terrestrial side: generator to receive pin, checker on send pin
    wr(bert_pkg::A_CTRL, 32'h15);
    wait_sec(2);
    rd(bert_pkg::A_STATUS); check(v, 32'h1);
    rd(bert_pkg::A_ERRORS); check(v, 32'h0);
    end_sim();
  end
endmodule
